// ---- pkg/wmcc_pkg.sv ----
// Package with register map, field layout, reset values and timing for the mode and calibration controller
package wmcc_pkg;

	// Register byte offsets
	localparam logic [11:0] OFS_MODE      = 12'h000;
	localparam logic [11:0] OFS_SCALE     = 12'h004;
	localparam logic [11:0] OFS_TESTWT    = 12'h008;
	localparam logic [11:0] OFS_ELECTRONIC_SPAN_CALC_CAP  = 12'h00C;
	localparam logic [11:0] OFS_ELECTRONIC_SPAN_CALC_OUT  = 12'h010;
	localparam logic [11:0] OFS_DEADLOAD  = 12'h014;
	localparam logic [11:0] OFS_CMD       = 12'h018;
	localparam logic [11:0] OFS_STATUS    = 12'h01C;
	localparam logic [11:0] OFS_IRQ_STAT  = 12'h020;
	localparam logic [11:0] OFS_IRQ_MASK  = 12'h024;
	localparam logic [11:0] OFS_ZERO_COEF = 12'h028;
	localparam logic [11:0] OFS_SPAN_COEF = 12'h02C;
	localparam logic [11:0] OFS_DIO_CFG   = 12'h030;
	localparam logic [11:0] OFS_SP1       = 12'h034;
	localparam logic [11:0] OFS_SP2       = 12'h038;
	localparam logic [11:0] OFS_SP3       = 12'h03C;
	localparam logic [11:0] OFS_MEAS      = 12'h040;

	// Mode register fields
	localparam int MODE_LSB  = 0;
	localparam int LEVEL_LSB = 2;
	localparam int POL_BIT   = 4;
	localparam int CFGOK_BIT = 5;

	typedef enum logic [1:0] {
		WMCC_MODE_COUNT = 2'h0,
		WMCC_MODE_WEIGH = 2'h1,
		WMCC_MODE_FORCE = 2'h2
	} wmcc_mode_t;

	typedef enum logic [1:0] {
		WMCC_LVL_5MV  = 2'h0,
		WMCC_LVL_10MV = 2'h1,
		WMCC_LVL_15MV = 2'h2,
		WMCC_LVL_18MV = 2'h3
	} wmcc_level_t;

	// Reset value of the mode register: count mode, 10 mV, unipolar
	localparam logic [31:0] MODE_RST = 32'h0000_0004;

	// Reset span coefficient: unity gain in 16.16
	localparam logic [31:0] SPAN_RST = 32'h0001_0000;

	// Full span counts per polarity
	localparam logic [21:0] SPAN_UNI = 22'h0F_4240;
	localparam logic [21:0] SPAN_BI  = 22'h1E_8480;

	// Command codes
	typedef enum logic [2:0] {
		WMCC_CMD_NONE     = 3'h0,
		WMCC_CMD_FULL     = 3'h1,
		WMCC_CMD_ZERO     = 3'h2,
		WMCC_CMD_SPAN     = 3'h3,
		WMCC_CMD_SPANLOAD = 3'h4,
		WMCC_CMD_ELECTRONIC_SPAN_CALC     = 3'h5,
		WMCC_CMD_ECALZERO = 3'h6,
		WMCC_CMD_SPANGO   = 3'h7
	} wmcc_cmd_t;
	localparam int CMD_RESTORE_BIT = 8;
	localparam int CMD_KEEP_BIT    = 9;

	// Status bits
	localparam int ST_BUSY    = 0;
	localparam int ST_WAITWT  = 1;
	localparam int ST_ERROR   = 2;
	localparam int ST_DONE    = 3;

	// Interrupt event bits
	localparam int EV_DONE  = 0;
	localparam int EV_ERROR = 1;
	localparam int EV_WAIT  = 2;

	// Timing
	localparam int  CLK_HZ        = 200_000_000;
	localparam int  MEAS_TIME_S   = 5;
	localparam longint MEAS_CYCLES = longint'(MEAS_TIME_S) * longint'(CLK_HZ);

endpackage

// ---- design/wmcc_meas.sv ----
// Averaging measurement unit for zero and span windows
`timescale 1ns/1ps
`default_nettype none
module wmcc_meas #(
	parameter int CYC_W = 32,
	parameter int DAT_W = 24
) (
	// Clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// Control
	input  wire logic                    start,
	input  wire logic [CYC_W-1:0]        length,
	// Sample stream
	input  wire logic                    smp_valid,
	input  wire logic signed [DAT_W-1:0] smp_data,
	input  wire logic                    smp_err,
	// Result
	output logic                         busy,
	output logic                         done,
	output logic                         fail,
	output logic signed [DAT_W-1:0]      result
);
	logic [CYC_W-1:0]        cnt_reg;
	logic signed [DAT_W+15:0] acc_reg;
	logic [15:0]             n_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy    <= 1'b0;
			done    <= 1'b0;
			fail    <= 1'b0;
			cnt_reg <= '0;
			acc_reg <= '0;
			n_reg   <= '0;
			result  <= '0;
		end else begin
			done <= 1'b0;
			fail <= 1'b0;
			if (start) begin
				busy    <= 1'b1;
				cnt_reg <= length;
				acc_reg <= '0;
				n_reg   <= '0;
			end else if (busy) begin
				if (smp_err) begin
					busy <= 1'b0;
					fail <= 1'b1;
				end else begin
					if (smp_valid && n_reg != 16'hFFFF) begin
						acc_reg <= acc_reg + (DAT_W+16)'(smp_data);
						n_reg   <= n_reg + 16'h0001;
					end
					if (cnt_reg <= 1) begin
						busy <= 1'b0;
						if (n_reg == 16'h0000) begin
							fail <= 1'b1;
						end else begin
							done   <= 1'b1;
							result <= DAT_W'(acc_reg / $signed({1'b0, n_reg}));
						end
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- design/wmcc_dio.sv ----
// Digital channel direction and polarity stage
`timescale 1ns/1ps
`default_nettype none
module wmcc_dio (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Configuration: per channel bit0 dir out, bit1 active low
	input  wire logic [5:0] cfg,
	input  wire logic [2:0] out_level,
	// Pins
	input  wire logic [2:0] pin_in,
	output logic [2:0]      pin_out,
	output logic [2:0]      pin_oe,
	// Input levels seen by logic
	output logic [2:0]      in_level
);
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= pin_in;
			sync2_reg <= sync1_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out  <= '0;
			pin_oe   <= 3'b001;
			in_level <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				pin_oe[i]   <= (i == 0) ? 1'b1 : cfg[2*i];
				pin_out[i]  <= out_level[i] ^ cfg[2*i+1];
				in_level[i] <= (i == 0) ? 1'b0 : (sync2_reg[i] ^ cfg[2*i+1]);
			end
		end
	end
endmodule
`default_nettype wire

// ---- design/wmcc_ctrl.sv ----
// Mode selection and calibration controller with APB register file
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R1] Three operating modes: count, weighing and force.
// [R2] Count mode passes filtered normalized converter counts unchanged.
// [R3] Count mode uses no scale build and no calibration coefficients.
// [R4] Weighing mode outputs only non-negative calibrated weight.
// [R5] Force mode outputs calibrated force, signed or clamped per polarity.
// [R6] Mode and polarity are written together in one register.
// [R7] Reset default is count mode, 10 mV, unipolar.
// [R8] Levels 5/10/15/18 mV; unipolar one million, bipolar two million counts. Electronic calibration uses the one million span in both polarities.
// [R9] Host loads capacity, increment and unit before calibrating.
// [R10] Full calibration: zero window, test weight, span window, auto store.
// [R11] Failure reports error; host restores old or keeps new coefficients.
// [R12] Standalone zero adjustment window, started by command.
// [R13] Standalone span adjustment with test weight, stored automatically.
// [R14] Span under load: temporary zero window, then span, auto store.
// [R15] Electronic calibration from capacity, cell capacity, output and dead load.
// [R16] Electronic calibration with measured zero instead of dead load. The code only measures and stores the zero; the span is kept.
// [R17] Three digital channels; first output only, others configurable.
// [R18] Each channel has function and polarity; setpoint n on channel n. Setpoints are only stored; outputs follow hostout_reg.
// [R19] Busy reported during every measurement window.
module wmcc_ctrl
	import wmcc_pkg::*;
#(
	parameter longint MEAS_LEN = MEAS_CYCLES,
	parameter int     DAT_W    = 24
) (
	// Clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Converter sample stream
	input  wire logic                    smp_valid,
	input  wire logic signed [DAT_W-1:0] smp_data,
	input  wire logic                    smp_err,
	// Digital channels
	input  wire logic [2:0]              dio_in,
	output logic [2:0]                   dio_out,
	output logic [2:0]                   dio_oe,
	// Interrupt
	output logic                         irq
);
	import wmcc_pkg::*;

	typedef enum logic [5:0] {
		S_IDLE   = 6'b000001,
		S_ZERO   = 6'b000010,
		S_WAITWT = 6'b000100,
		S_SPAN   = 6'b001000,
		S_STORE  = 6'b010000,
		S_ERR    = 6'b100000
	} wmcc_state_t;

	wmcc_state_t      state_reg;
	logic [31:0]      mode_reg;
	logic [31:0]      scale_reg;
	logic [31:0]      testwt_reg;
	logic [31:0]      ecap_reg;
	logic [31:0]      eout_reg;
	logic [31:0]      dead_reg;
	logic [31:0]      zero_reg;
	logic [31:0]      span_reg;
	logic [31:0]      zero_old_reg;
	logic [31:0]      span_old_reg;
	logic [31:0]      zero_new_reg;
	logic [31:0]      span_new_reg;
	logic [31:0]      meas_reg;
	logic [5:0]       dio_cfg_reg;
	logic [31:0]      sp_reg [3];
	logic [2:0]       hostout_reg;
	logic [2:0]       irq_stat_reg;
	logic [2:0]       irq_mask_reg;
	logic             done_reg;
	logic             err_reg;
	logic             tempzero_reg;
	logic             ecalzero_reg;
	logic [2:0]       dio_level;
	logic             m_start;
	logic             m_busy;
	logic             m_done;
	logic             m_fail;
	logic signed [DAT_W-1:0] m_res;
	logic             wr_en;
	logic             rd_en;
	logic [2:0]       cmd;
	logic             valid_addr;
	logic             scale_ok;
	logic signed [31:0] calc;

	function automatic logic [31:0] span_of(input logic [31:0] delta, input logic [31:0] wt);
		span_of = (delta == 32'h0000_0000) ? 32'h0000_0000 : 32'((64'(wt) << 16) / 64'(delta));
	endfunction

	assign wr_en    = psel && penable && pwrite;
	assign rd_en    = psel && penable && !pwrite;
	assign cmd      = pwdata[2:0];
	assign scale_ok = scale_reg != 32'h0000_0000;
	assign valid_addr = paddr[1:0] == 2'b00 && paddr <= OFS_MEAS;

	wmcc_meas #(
		.CYC_W (32),
		.DAT_W (DAT_W)
	) u_meas (
		.pclk      (pclk),
		.presetn   (presetn),
		.start     (m_start),
		.length    (32'(MEAS_LEN)),
		.smp_valid (smp_valid),
		.smp_data  (smp_data),
		.smp_err   (smp_err),
		.busy      (m_busy),
		.done      (m_done),
		.fail      (m_fail),
		.result    (m_res)
	);

	wmcc_dio u_dio (
		.pclk      (pclk),
		.presetn   (presetn),
		.cfg       (dio_cfg_reg),
		.out_level (hostout_reg),
		.pin_in    (dio_in),
		.pin_out   (dio_out),
		.pin_oe    (dio_oe),
		.in_level  (dio_level)
	);

	// APB answers in the access phase with no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !valid_addr;
		end
	end

	// Configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg    <= MODE_RST; // [R7]
			scale_reg   <= '0;
			testwt_reg  <= '0;
			ecap_reg    <= '0;
			eout_reg    <= '0;
			dead_reg    <= '0;
			dio_cfg_reg <= 6'h01;
			hostout_reg <= '0;
			irq_mask_reg <= '0;
			for (int i = 0; i < 3; i++) begin
				sp_reg[i] <= '0;
			end
		end else if (wr_en && pready && (state_reg == S_IDLE || paddr == OFS_TESTWT)) begin
			case (paddr)
				OFS_MODE: begin
					if (pwdata[1:0] != 2'h3) begin
						mode_reg <= {26'h0, 1'b1, pwdata[4:0]}; // [R6] [R1] [R8]
					end
				end
				OFS_SCALE:    scale_reg  <= pwdata; // [R9]
				OFS_TESTWT:   testwt_reg <= pwdata;
				OFS_ELECTRONIC_SPAN_CALC_CAP: ecap_reg   <= pwdata;
				OFS_ELECTRONIC_SPAN_CALC_OUT: eout_reg   <= pwdata;
				OFS_DEADLOAD: dead_reg   <= pwdata;
				OFS_IRQ_MASK: irq_mask_reg <= pwdata[2:0];
				OFS_DIO_CFG: begin
					dio_cfg_reg <= {pwdata[5:2], pwdata[1], 1'b1}; // [R17] [R18]
					hostout_reg <= pwdata[10:8];
				end
				OFS_SP1: sp_reg[0] <= pwdata; // [R18]
				OFS_SP2: sp_reg[1] <= pwdata;
				OFS_SP3: sp_reg[2] <= pwdata;
				default: ;
			endcase
		end
	end

	// Calibration sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg    <= S_IDLE;
			m_start      <= 1'b0;
			zero_reg     <= '0;
			span_reg     <= SPAN_RST;
			zero_old_reg <= '0;
			span_old_reg <= SPAN_RST;
			zero_new_reg <= '0;
			span_new_reg <= '0;
			done_reg     <= 1'b0;
			err_reg      <= 1'b0;
			tempzero_reg <= 1'b0;
			ecalzero_reg <= 1'b0;
		end else begin
			m_start  <= 1'b0;
			done_reg <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					if (wr_en && pready && paddr == OFS_CMD && mode_reg[1:0] != WMCC_MODE_COUNT && scale_ok) begin // [R3] [R9]
						zero_old_reg <= zero_reg;
						span_old_reg <= span_reg;
						zero_new_reg <= zero_reg;
						span_new_reg <= span_reg;
						tempzero_reg <= 1'b0;
						ecalzero_reg <= 1'b0;
						case (cmd)
							WMCC_CMD_FULL, WMCC_CMD_ZERO: begin // [R10] [R12]
								m_start   <= 1'b1;
								state_reg <= S_ZERO;
							end
							WMCC_CMD_SPAN: begin // [R13]
								m_start   <= 1'b1;
								state_reg <= S_SPAN;
							end
							WMCC_CMD_SPANLOAD: begin // [R14]
								tempzero_reg <= 1'b1;
								m_start      <= 1'b1;
								state_reg    <= S_ZERO;
							end
							WMCC_CMD_ELECTRONIC_SPAN_CALC: begin // [R15]
								zero_new_reg <= dead_reg;
								span_new_reg <= span_of(32'((64'(eout_reg) * 64'(SPAN_UNI)) >> 16), ecap_reg);
								state_reg    <= S_STORE;
							end
							WMCC_CMD_ECALZERO: begin // [R16]
								ecalzero_reg <= 1'b1;
								m_start      <= 1'b1;
								state_reg    <= S_ZERO;
							end
							default: ;
						endcase
						if (cmd == WMCC_CMD_ZERO) begin
							ecalzero_reg <= 1'b1;
						end
					end
				end
				S_ZERO: begin
					if (m_fail) begin
						state_reg <= S_ERR;
						err_reg   <= 1'b1; // [R11]
					end else if (m_done) begin
						zero_new_reg <= 32'(m_res);
						if (ecalzero_reg) begin
							state_reg <= S_STORE; // [R12] [R16]
						end else begin
							state_reg <= S_WAITWT; // [R10] [R14]
						end
					end
				end
				S_WAITWT: begin
					if (wr_en && pready && paddr == OFS_CMD && cmd == WMCC_CMD_SPANGO) begin
						m_start   <= 1'b1;
						state_reg <= S_SPAN;
					end
				end
				S_SPAN: begin
					if (m_fail) begin
						state_reg <= S_ERR;
						err_reg   <= 1'b1; // [R11]
					end else if (m_done) begin
						span_new_reg <= span_of(32'(m_res) - zero_new_reg, testwt_reg); // [R13] [R14]
						state_reg    <= S_STORE;
					end
				end
				S_STORE: begin
					if (!tempzero_reg) begin
						zero_reg <= zero_new_reg;
					end
					span_reg  <= span_new_reg; // [R10] [R13] [R14]
					done_reg  <= 1'b1;
					err_reg   <= 1'b0;
					state_reg <= S_IDLE;
				end
				S_ERR: begin
					if (wr_en && pready && paddr == OFS_CMD) begin
						if (pwdata[CMD_RESTORE_BIT]) begin // [R11]
							zero_reg  <= zero_old_reg;
							span_reg  <= span_old_reg;
							err_reg   <= 1'b0;
							state_reg <= S_IDLE;
						end else if (pwdata[CMD_KEEP_BIT]) begin
							zero_reg  <= tempzero_reg ? zero_reg : zero_new_reg;
							span_reg  <= span_new_reg;
							err_reg   <= 1'b0;
							state_reg <= S_IDLE;
						end
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// Measured value per mode
	always_comb begin
		calc = 32'((64'(signed'(32'(smp_data)) - signed'(zero_reg)) * 64'(span_reg)) >>> 16);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meas_reg <= '0;
		end else if (smp_valid) begin
			case (mode_reg[1:0])
				WMCC_MODE_COUNT: meas_reg <= 32'(smp_data); // [R2] [R3]
				WMCC_MODE_WEIGH: meas_reg <= calc[31] ? 32'h0000_0000 : calc; // [R4]
				WMCC_MODE_FORCE: meas_reg <= (!mode_reg[POL_BIT] && calc[31]) ? 32'h0000_0000 : calc; // [R5]
				default:         meas_reg <= '0;
			endcase
		end
	end

	// Sticky interrupt status, set wins; a read clears only the bits it returned
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= '0;
			irq          <= 1'b0;
		end else begin
			irq_stat_reg <= ((rd_en && pready && paddr == OFS_IRQ_STAT) ? (irq_stat_reg & ~prdata[2:0]) : irq_stat_reg)
				| {state_reg == S_ZERO && m_done && !ecalzero_reg, m_fail, done_reg};
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// Read mux
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				OFS_MODE:      prdata <= mode_reg;
				OFS_SCALE:     prdata <= scale_reg;
				OFS_TESTWT:    prdata <= testwt_reg;
				OFS_ELECTRONIC_SPAN_CALC_CAP:  prdata <= ecap_reg;
				OFS_ELECTRONIC_SPAN_CALC_OUT:  prdata <= eout_reg;
				OFS_DEADLOAD:  prdata <= dead_reg;
				OFS_STATUS:    prdata <= {28'h0, done_reg, err_reg, state_reg == S_WAITWT, m_busy}; // [R19]
				OFS_IRQ_STAT:  prdata <= {29'h0, irq_stat_reg};
				OFS_IRQ_MASK:  prdata <= {29'h0, irq_mask_reg};
				OFS_ZERO_COEF: prdata <= zero_reg;
				OFS_SPAN_COEF: prdata <= span_reg;
				OFS_DIO_CFG:   prdata <= {21'h0, hostout_reg, 2'b00, dio_cfg_reg};
				OFS_SP1:       prdata <= sp_reg[0];
				OFS_SP2:       prdata <= sp_reg[1];
				OFS_SP3:       prdata <= sp_reg[2];
				OFS_MEAS:      prdata <= meas_reg;
				default:       prdata <= {29'h0, dio_level};
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- sim/wmcc_ctrl_props.sv ----
// Port checker for the mode and calibration controller
`timescale 1ns/1ps
`default_nettype none
module wmcc_ctrl_props
	import wmcc_pkg::*;
#(
	parameter longint MEAS_LEN = MEAS_CYCLES,
	parameter int     DAT_W    = 24
) (
	// Clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// APB
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	input  wire logic [31:0]             prdata,
	input  wire logic                    pready,
	input  wire logic                    pslverr,
	// Samples
	input  wire logic                    smp_valid,
	input  wire logic signed [DAT_W-1:0] smp_data,
	input  wire logic                    smp_err,
	// Channels and interrupt
	input  wire logic [2:0]              dio_in,
	input  wire logic [2:0]              dio_out,
	input  wire logic [2:0]              dio_oe,
	input  wire logic                    irq
);
	logic [4:0] mode_shadow;

	// Expected mode, level and polarity after accepted writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_shadow <= MODE_RST[4:0];
		end else if (psel && penable && pready && pwrite && paddr == OFS_MODE && pwdata[1:0] != 2'h3) begin
			mode_shadow <= pwdata[4:0];
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_access_ready;
		psel && !penable |=> pready;
	endproperty
	a_access_ready: assert property (p_access_ready) else $error("no ready in access cycle");
	property p_ready_single;
		pready |=> !pready;
	endproperty
	a_ready_single: assert property (p_ready_single) else $error("ready held too long");
	property p_ready_cause;
		$rose(pready) |-> $past(psel && !penable);
	endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
	property p_bad_addr;
		psel && !penable && (paddr[1:0] != 2'h0 || paddr > OFS_MEAS) |=> pslverr;
	endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("bad address not flagged");
	property p_good_addr;
		psel && !penable && paddr[1:0] == 2'h0 && paddr <= OFS_MEAS |=> !pslverr;
	endproperty
	a_good_addr: assert property (p_good_addr) else $error("good address flagged");
	property p_err_with_ready;
		pslverr |-> pready;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
	property p_mode_read;
		psel && !penable && !pwrite && paddr == OFS_MODE |=> prdata[4:0] == mode_shadow;
	endproperty
	a_mode_read: assert property (p_mode_read) else $error("mode readback wrong");
	property p_ch1_out;
		dio_oe[0];
	endproperty
	a_ch1_out: assert property (p_ch1_out) else $error("first channel not driving");

	c_irq: cover property ($rose(irq));
	c_err: cover property (pslverr);
	c_cmd: cover property (psel && penable && pwrite && paddr == OFS_CMD);
endmodule

bind wmcc_ctrl wmcc_ctrl_props #(.MEAS_LEN(MEAS_LEN), .DAT_W(DAT_W)) u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .smp_valid(smp_valid), .smp_data(smp_data), .smp_err(smp_err),
	.dio_in(dio_in), .dio_out(dio_out), .dio_oe(dio_oe), .irq(irq));
`default_nettype wire

// ---- sim/wmcc_smp_src.sv ----
// Converter sample source model, one sample every four cycles
`timescale 1ns/1ps
`default_nettype none
module wmcc_smp_src #(
	parameter int DAT_W = 24
) (
	// Clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// Fault request: no samples and error level
	input  wire logic                    fault,
	// Sample stream
	output logic                         smp_valid,
	output logic signed [DAT_W-1:0]      smp_data,
	output logic                         smp_err
);
	logic [1:0] div_reg;

	// Data toggles between samples so stale values are never seen as valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg   <= 2'h0;
			smp_valid <= 1'b0;
			smp_data  <= '0;
			smp_err   <= 1'b0;
		end else begin
			div_reg   <= div_reg + 2'h1;
			smp_valid <= (div_reg == 2'h3) && !fault;
			smp_data  <= (div_reg == 2'h3) ? DAT_W'(32'h0001_2345) : ~smp_data;
			smp_err   <= fault;
		end
	end
endmodule
`default_nettype wire

// ---- sim/wmcc_ctrl_bench.sv ----
// Register level testbench for the mode and calibration controller
`timescale 1ns/1ps
`default_nettype none
module wmcc_ctrl_bench;
	import wmcc_pkg::*;
	logic               pclk;
	logic               presetn;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic [11:0]        paddr;
	logic [31:0]        pwdata;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic               smp_valid;
	logic signed [23:0] smp_data;
	logic               smp_err;
	logic               fault;
	logic [2:0]         dio_in;
	logic [2:0]         dio_out;
	logic [2:0]         dio_oe;
	logic               irq;
	logic [31:0]        rd;
	logic               err;
	logic [2:0]         cmds [6];
	int                 error_cnt;
	int                 total_checks;

	wmcc_ctrl #(.MEAS_LEN(100), .DAT_W(24)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.smp_valid(smp_valid), .smp_data(smp_data), .smp_err(smp_err), .dio_in(dio_in), .dio_out(dio_out),
		.dio_oe(dio_oe), .irq(irq));
	wmcc_smp_src #(.DAT_W(24)) u_src (.pclk(pclk), .presetn(presetn), .fault(fault), .smp_valid(smp_valid),
		.smp_data(smp_data), .smp_err(smp_err));

	initial pclk = 1'b0;
	always #2.5 pclk = ~pclk;

	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			wrap_up();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 1000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 1000) begin
			error_cnt++;
			wrap_up();
		end
	endtask

	// Runs one sequence, enters the test weight where asked, checks the final event
	task automatic cal(input logic [2:0] c, input logic [31:0] exp);
		xfer(1'b1, OFS_CMD, {29'h0, c});
		if (c != WMCC_CMD_ELECTRONIC_SPAN_CALC && exp == 32'h1) begin
			xfer(1'b0, OFS_STATUS, 32'h0);
			chk(rd & 32'h1, 32'h1);
		end
		if (c == WMCC_CMD_FULL || c == WMCC_CMD_SPANLOAD) begin
			wait_irq();
			xfer(1'b0, OFS_STATUS, 32'h0);
			chk(rd & 32'h3, 32'h2);
			xfer(1'b0, OFS_IRQ_STAT, 32'h0);
			chk(rd, 32'h4);
			xfer(1'b1, OFS_TESTWT, 32'h0000_1000);
			xfer(1'b1, OFS_CMD, {29'h0, WMCC_CMD_SPANGO});
		end
		wait_irq();
		xfer(1'b0, OFS_IRQ_STAT, 32'h0);
		chk(rd, exp);
	endtask

	initial begin
		#450us;
		error_cnt++;
		wrap_up();
	end

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		fault = 1'b0;
		dio_in = 3'h5;
		presetn = 1'b0;
		error_cnt = 0;
		total_checks = 0;
		cmds = '{WMCC_CMD_ZERO, WMCC_CMD_SPAN, WMCC_CMD_FULL, WMCC_CMD_SPANLOAD, WMCC_CMD_ELECTRONIC_SPAN_CALC, WMCC_CMD_ECALZERO};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, OFS_MODE, 32'h0);
		chk(rd & 32'h1F, MODE_RST);
		xfer(1'b1, OFS_MODE, 32'h0000_0003);
		xfer(1'b0, OFS_MODE, 32'h0);
		chk(rd & 32'h1F, MODE_RST);
		for (int m = 0; m < 3; m++) begin
			for (int v = 0; v < 8; v++) begin
				xfer(1'b1, OFS_MODE, 32'(v * 4 + m));
				xfer(1'b0, OFS_MODE, 32'h0);
				chk(rd & 32'h1F, 32'(v * 4 + m));
			end
		end
		xfer(1'b1, OFS_MODE, 32'h0000_0004);
		xfer(1'b1, OFS_SCALE, 32'h0001_0001);
		xfer(1'b1, OFS_CMD, {29'h0, WMCC_CMD_ZERO});
		xfer(1'b0, OFS_STATUS, 32'h0);
		chk(rd & 32'h1, 32'h0);
		xfer(1'b0, OFS_MEAS, 32'h0);
		chk(rd, 32'h0001_2345);
		xfer(1'b1, OFS_MODE, 32'h0000_0005);
		xfer(1'b1, OFS_SCALE, 32'h0);
		xfer(1'b1, OFS_CMD, {29'h0, WMCC_CMD_ZERO});
		xfer(1'b0, OFS_STATUS, 32'h0);
		chk(rd & 32'h1, 32'h0);
		xfer(1'b1, OFS_SCALE, 32'h0001_0001);
		xfer(1'b1, OFS_ELECTRONIC_SPAN_CALC_CAP, 32'h0000_0FA0);
		xfer(1'b1, OFS_ELECTRONIC_SPAN_CALC_OUT, 32'h0002_0000);
		xfer(1'b1, OFS_DEADLOAD, 32'h0000_0064);
		xfer(1'b1, OFS_TESTWT, 32'h0000_1000);
		xfer(1'b1, OFS_IRQ_MASK, 32'h7);
		foreach (cmds[i]) begin
			cal(cmds[i], 32'h1);
		end
		xfer(1'b0, OFS_ZERO_COEF, 32'h0);
		chk(rd, 32'h0001_2345);
		xfer(1'b0, OFS_IRQ_STAT, 32'h0);
		chk(rd, 32'h0);
		// First pass restores the old coefficients, second keeps the new ones
		for (int k = 0; k < 2; k++) begin
			fault <= 1'b1;
			cal(WMCC_CMD_ZERO, 32'h2);
			xfer(1'b0, OFS_STATUS, 32'h0);
			chk(rd & 32'h4, 32'h4);
			fault <= 1'b0;
			xfer(1'b1, OFS_CMD, 32'(256 << k));
			xfer(1'b0, OFS_STATUS, 32'h0);
			chk(rd & 32'h4, 32'h0);
		end
		xfer(1'b1, OFS_IRQ_MASK, 32'h0);
		xfer(1'b1, OFS_CMD, {29'h0, WMCC_CMD_ZERO});
		repeat (300) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		xfer(1'b1, OFS_IRQ_MASK, 32'h1);
		repeat (3) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		xfer(1'b0, OFS_IRQ_STAT, 32'h0);
		chk(rd, 32'h1);
		repeat (3) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		xfer(1'b0, 12'h044, 32'h0);
		chk({31'h0, err}, 32'h1);
		xfer(1'b0, 12'h002, 32'h0);
		chk({31'h0, err}, 32'h1);
		xfer(1'b1, OFS_DIO_CFG, 32'h0000_0318);
		repeat (3) @(posedge pclk);
		chk({29'h0, dio_oe}, 32'h5);
		chk({29'h0, dio_out}, 32'h1);
		xfer(1'b1, OFS_DIO_CFG, 32'h0);
		repeat (3) @(posedge pclk);
		chk({29'h0, dio_oe}, 32'h1);
		chk({29'h0, dio_out}, 32'h0);
		for (int i = 0; i < 3; i++) begin
			xfer(1'b1, OFS_SP1 + 12'(i * 4), 32'(256 + i));
			xfer(1'b0, OFS_SP1 + 12'(i * 4), 32'h0);
			chk(rd, 32'(256 + i));
		end
		wrap_up();
	end
endmodule
`default_nettype wire
